// ### bench/bus_host.sv
// Serial bus host with pull-up.
// Assumes one caller at a time.
module bus_host (
  // Clock
  input wire logic clk,
  // Device driver
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Bus lines
  output logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pullLow;
  // Released line floats high
  assign sda = !(pullLow || (sdaOe && !sdaOut));
  initial begin
    scl = 1'b1;
    pullLow = 1'b0;
  end
  //////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  task automatic start();
    pullLow = 1'b0;
    hold(8);
    scl = 1'b1;
    hold(4);
    pullLow = 1'b1;
    hold(4);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    pullLow = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(4);
    pullLow = 1'b0;
    hold(8);
  endtask : stop
  // Data moves mid-low, sampled late high
  task automatic bitx(input logic b, output logic r);
    hold(4);
    pullLow = !b;
    hold(4);
    scl = 1'b1;
    hold(8);
    r = sda;
    scl = 1'b0;
  endtask : bitx
  // Ninth bit a: 0 acknowledges a read byte, 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(a, ack);
  endtask : xfer
endmodule : bus_host

// ### bench/conditioner_chk.sv
// Checker bound to the configuration block ports.
// Assumes straps hold five clocks per step.
module conditioner_chk import conditioner_pkg::*; (
  // Clock
  input wire logic clk,
  input wire logic reset_n,
  // Bus
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Straps and settings
  input strap_levels_type straps,
  input settings_type settings
);
  timeunit 1ns;
  timeprecision 100ps;
  // One nibble per high/low level pair
  localparam logic [63:0] EqTab = 64'h6547_9AB8_CFED_3012;
  localparam logic [7:0] GainTab = 8'h1E;
  logic [2:0] upCnt;
  logic [2:0] next_upCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////
  // Masks history from before reset
  always_comb begin
    next_upCnt = upCnt + {2'h0, upCnt != 3'h7};
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upCnt <= 3'h0;
    end else begin
      upCnt <= next_upCnt;
    end
  end
  ctrl_reset_a: assert property (
    upCnt == 3'h1 |-> settings[15:8] == 8'h70)
    else $error("bad power-up byte");
  thresh_write_a: assert property (
    upCnt == 3'h7 && $changed(settings.signalDetectThreshold)
      |-> ##[0:8] sdaOe)
    else $error("threshold moved unasked");
  thresh_hold_a: assert property (
    upCnt == 3'h7 && $changed(settings.signalDetectThreshold)
      |=> $stable(settings.signalDetectThreshold) [*8])
    else $error("threshold not held");
  rsvd_write_a: assert property (
    upCnt == 3'h7 && $changed(settings.reservedBits) |-> ##[0:8] sdaOe)
    else $error("reserved moved unasked");
  eq_decode_a: assert property (
    (upCnt == 3'h7 && $stable(straps)) [*5] |-> settings.equalizerCode ==
      EqTab[{straps.equalizerStrapHigh, straps.equalizerStrapLow} * 4 +: 4])
    else $error("bad equalizer code");
  gain_decode_a: assert property (
    (upCnt == 3'h7 && $stable(straps)) [*5] |->
      settings.flatGainCode == GainTab[straps.flatGainStrap * 2 +: 2])
    else $error("bad gain code");
  swing_decode_a: assert property (
    (upCnt == 3'h7 && $stable(straps)) [*5] |->
      settings.outputSwingCode == straps.outputSwingStrap)
    else $error("bad swing code");
  drive_low_a: assert property (
    sdaOe |-> !sdaOut)
    else $error("data line driven high");
endmodule : conditioner_chk

bind conditioner_config conditioner_chk conditioner_chk_i (.clk(clk),
  .reset_n(reset_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .straps(straps), .settings(settings));

// ### bench/tb_top.sv
// Bench: bus accesses and a strap sweep.
// Assumes bus_host and the bound checker.
`include "conditioner_cfg.svh"
module tb_top import conditioner_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic reset_n;
  logic scl;
  logic sda;
  logic sdaOut;
  logic sdaOe;
  strap_levels_type straps;
  settings_type settings;
  int mismatches = 0;
  int compares = 0;
  logic [7:0] q;
  logic ack;
  conditioner_config conditioner_config_i (.clk(clk), .reset_n(reset_n),
    .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .straps(straps), .settings(settings));
  bus_host bus_host_i (.clk(clk), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .scl(scl), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic send(input logic [7:0] d);
    bus_host_i.xfer(d, 1'b1, q, ack);
  endtask : send
  task automatic point(input logic [7:0] idx);
    bus_host_i.start();
    send({`CFG_DEVICE_ADDR, 1'b0});
    send(idx);
  endtask : point
  task automatic wr(input logic [7:0] idx, d);
    point(idx);
    send(d);
    check("write ack", {7'h00, ack}, 8'h00);
    bus_host_i.stop();
  endtask : wr
  task automatic rd(input logic [7:0] idx, exp);
    point(idx);
    bus_host_i.start();
    send({`CFG_DEVICE_ADDR, 1'b1});
    send(8'hFF);
    bus_host_i.stop();
    check("read byte", q, exp);
  endtask : rd
  initial begin
    reset_n = 1'b0;
    straps = '0;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("power-up", settings[15:8], 8'h70);
    rd(8'h0C, 8'h70);
    for (int c = 0; c < 4; c++) begin
      // Reserved bits go back at power-up value
      wr(8'h0C, {c[1:0], 6'h30});
      check("thr", {6'h00, settings.signalDetectThreshold}, 8'(c));
      rd(8'h0C, {c[1:0], 6'h30});
    end
    wr(8'h0C, 8'hB0);
    check("reserved", {2'h0, settings.reservedBits}, 8'h30);
    wr(8'h0D, 8'hFF);
    rd(8'h0C, 8'hB0);
    rd(8'h0D, 8'h00);
    // Two-byte read: acknowledged first byte, then the control byte
    point(8'h0B);
    bus_host_i.start();
    send({`CFG_DEVICE_ADDR, 1'b1});
    bus_host_i.xfer(8'hFF, 1'b0, q, ack);
    check("burst first", q, 8'h00);
    send(8'hFF);
    bus_host_i.stop();
    check("burst second", q, 8'hB0);
    bus_host_i.start();
    send({`CFG_DEVICE_ADDR ^ 7'h01, 1'b0});
    bus_host_i.stop();
    check("foreign ack", {7'h00, ack}, 8'h01);
    // Mid-run reset brings the control byte back to power-up value
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rd(8'h0C, 8'h70);
    wr(8'h0C, 8'h70);
    for (int i = 0; i < 256; i++) begin
      straps = i[7:0];
      repeat (8) @(posedge clk);
      #1;
    end
    check("strap codes", settings[7:0], 8'h63);
    tally_and_finish();
  end
endmodule : tb_top

// ### hdl/conditioner_cfg.svh
// Constants of the signal-conditioner configuration block.
// Assumes a single 40 MHz clock domain and an open-drain serial bus.
//
// Summary of operation
// - Threshold field bits 7:6, resets to 01.
// - Threshold codes 00/01/10 give 50/65/80 mV.
// - Bits 5:0 reserved, stored and read back.
// - Equalizer straps decode to 4-bit code.
// - Flat gain strap decodes R/F/0/1 to 00..11.
// - Swing strap decodes 0/1/F/R to 00..11.
`ifndef CONDITIONER_CFG_SVH
`define CONDITIONER_CFG_SVH

// Bus device address, value arbitrary
`define CFG_DEVICE_ADDR 7'h2A
`define CFG_CTRL_INDEX 8'h0C
`define CFG_CTRL_RESET 8'h70
`define CFG_THRESH_MSB 7
`define CFG_THRESH_LSB 6
`define CFG_RSVD_MSB 5
`define CFG_BYTE_BITS 4'h8
`define CFG_LAST_BIT 4'h7
`define CFG_IDLE_READ 8'h00

`endif

// ### hdl/conditioner_config.sv
// Control byte behind an open-drain serial slave, plus strap decoding.
// Assumes scl/sda and strap levels arrive asynchronously to clk.
`include "conditioner_cfg.svh"

module conditioner_config import conditioner_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial bus pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Strap pins
  input strap_levels_type straps,
  // Settings to the analog side
  output settings_type settings
);

  typedef enum logic [2:0] {
    IDLE,
    ADDR,
    ADDR_ACK,
    INDEX,
    WDATA,
    RX_ACK,
    TX,
    TX_ACK
  } bus_state_type;

  //////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic logic [3:0] eqDecode(strap_level_type hi,
                                          strap_level_type lo);
    logic [3:0] code;
    code = 4'h0;
    unique case ({hi, lo})
      {LEVEL_0, LEVEL_F}: code = 4'h0;
      {LEVEL_0, LEVEL_1}: code = 4'h1;
      {LEVEL_0, LEVEL_0}: code = 4'h2;
      {LEVEL_0, LEVEL_R}: code = 4'h3;
      {LEVEL_R, LEVEL_1}: code = 4'h4;
      {LEVEL_R, LEVEL_F}: code = 4'h5;
      {LEVEL_R, LEVEL_R}: code = 4'h6;
      {LEVEL_R, LEVEL_0}: code = 4'h7;
      {LEVEL_F, LEVEL_0}: code = 4'h8;
      {LEVEL_F, LEVEL_R}: code = 4'h9;
      {LEVEL_F, LEVEL_F}: code = 4'hA;
      {LEVEL_F, LEVEL_1}: code = 4'hB;
      {LEVEL_1, LEVEL_R}: code = 4'hC;
      {LEVEL_1, LEVEL_0}: code = 4'hD;
      {LEVEL_1, LEVEL_1}: code = 4'hE;
      {LEVEL_1, LEVEL_F}: code = 4'hF;
    endcase
    return code;
  endfunction : eqDecode

  function automatic logic [1:0] gainDecode(strap_level_type lvl);
    logic [1:0] code;
    code = 2'h1;
    unique case (lvl)
      LEVEL_R: code = 2'h0;
      LEVEL_F: code = 2'h1;
      LEVEL_0: code = 2'h2;
      LEVEL_1: code = 2'h3;
    endcase
    return code;
  endfunction : gainDecode

  function automatic logic [1:0] swingDecode(strap_level_type lvl);
    logic [1:0] code;
    code = 2'h1;
    unique case (lvl)
      LEVEL_0: code = 2'h0;
      LEVEL_1: code = 2'h1;
      LEVEL_F: code = 2'h2;
      LEVEL_R: code = 2'h3;
    endcase
    return code;
  endfunction : swingDecode

  function automatic logic [7:0] readByte(logic [7:0] index,
                                          logic [7:0] ctrl);
    return (index == `CFG_CTRL_INDEX) ? ctrl : `CFG_IDLE_READ;
  endfunction : readByte

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers

  logic [2:0] sclSync;
  logic [2:0] sdaSync;
  strap_levels_type strapMeta;
  strap_levels_type strapSync;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      strapMeta <= '0;
      strapSync <= '0;
    end else begin
      sclSync <= {sclSync[1:0], scl};
      sdaSync <= {sdaSync[1:0], sdaIn};
      strapMeta <= straps;
      strapSync <= strapMeta;
    end
  end

  // Edge terms look only at stages 1 and 2, never the first stage
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sdaBit;

  assign sclRise = sclSync[1] && !sclSync[2];
  assign sclFall = !sclSync[1] && sclSync[2];
  assign startSeen = sclSync[1] && sclSync[2] && !sdaSync[1] && sdaSync[2];
  assign stopSeen = sclSync[1] && sclSync[2] && sdaSync[1] && !sdaSync[2];
  assign sdaBit = sdaSync[1];

  //////////////////////////////////////////////////////////////////////////
  // Bus slave and control byte

  bus_state_type state;
  bus_state_type next_state;
  logic [3:0] bitCount;
  logic [3:0] next_bitCount;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic [7:0] pointer;
  logic [7:0] next_pointer;
  logic [7:0] ctrlReg;
  logic [7:0] next_ctrlReg;
  logic isRead;
  logic next_isRead;
  logic nacked;
  logic next_nacked;

  always_comb begin
    next_state = state;
    next_bitCount = bitCount;
    next_shiftReg = shiftReg;
    next_pointer = pointer;
    next_ctrlReg = ctrlReg;
    next_isRead = isRead;
    next_nacked = nacked;
    if (startSeen) begin
      next_state = ADDR;
      next_bitCount = 4'h0;
    end else if (stopSeen) begin
      next_state = IDLE;
    end else begin
      unique case (state)
        IDLE: begin
        end
        ADDR, INDEX, WDATA: begin
          if (sclRise && bitCount < `CFG_BYTE_BITS) begin
            next_shiftReg = {shiftReg[6:0], sdaBit};
            next_bitCount = bitCount + 4'h1;
          end else if (sclFall && bitCount == `CFG_BYTE_BITS) begin
            next_state = RX_ACK;
            if (state == ADDR) begin
              next_isRead = shiftReg[0];
              next_state = (shiftReg[7:1] == `CFG_DEVICE_ADDR) ?
                           ADDR_ACK : IDLE;
            end else if (state == INDEX) begin
              next_pointer = shiftReg;
            end else begin
              if (pointer == `CFG_CTRL_INDEX) begin
                next_ctrlReg = shiftReg;
              end
              next_pointer = pointer + 8'h01;
            end
          end
        end
        ADDR_ACK: begin
          if (sclFall) begin
            next_bitCount = 4'h0;
            if (isRead) begin
              next_shiftReg = readByte(pointer, ctrlReg);
              next_pointer = pointer + 8'h01;
              next_state = TX;
            end else begin
              next_state = INDEX;
            end
          end
        end
        RX_ACK: begin
          if (sclFall) begin
            next_bitCount = 4'h0;
            next_state = WDATA;
          end
        end
        TX: begin
          if (sclFall) begin
            if (bitCount == `CFG_LAST_BIT) begin
              next_state = TX_ACK;
            end else begin
              next_shiftReg = {shiftReg[6:0], 1'b0};
              next_bitCount = bitCount + 4'h1;
            end
          end
        end
        TX_ACK: begin
          if (sclRise) begin
            next_nacked = sdaBit;
          end else if (sclFall) begin
            next_bitCount = 4'h0;
            if (nacked) begin
              next_state = IDLE;
            end else begin
              next_shiftReg = readByte(pointer, ctrlReg);
              next_pointer = pointer + 8'h01;
              next_state = TX;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= IDLE;
      bitCount <= 4'h0;
      shiftReg <= 8'h00;
      pointer <= 8'h00;
      ctrlReg <= `CFG_CTRL_RESET;
      isRead <= 1'b0;
      nacked <= 1'b0;
    end else begin
      state <= next_state;
      bitCount <= next_bitCount;
      shiftReg <= next_shiftReg;
      pointer <= next_pointer;
      ctrlReg <= next_ctrlReg;
      isRead <= next_isRead;
      nacked <= next_nacked;
    end
  end

  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = (state == ADDR_ACK) || (state == RX_ACK) ||
                 ((state == TX) && !shiftReg[7]);

  //////////////////////////////////////////////////////////////////////////
  // Settings to the analog side

  settings_type next_settings;

  always_comb begin
    // Threshold code drives the detector directly; 11 is not filtered
    next_settings.signalDetectThreshold =
      ctrlReg[`CFG_THRESH_MSB:`CFG_THRESH_LSB];
    next_settings.reservedBits = ctrlReg[`CFG_RSVD_MSB:0];
    next_settings.equalizerCode = eqDecode(strapSync.equalizerStrapHigh,
      strapSync.equalizerStrapLow);
    next_settings.flatGainCode = gainDecode(strapSync.flatGainStrap);
    next_settings.outputSwingCode = swingDecode(strapSync.outputSwingStrap);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settings <= '0;
    end else begin
      settings <= next_settings;
    end
  end

endmodule : conditioner_config

// ### hdl/conditioner_pkg.sv
// Types shared by the configuration block and its bench.
// Assumes the strap front end reports one of four levels per pin.
package conditioner_pkg;

  typedef enum logic [1:0] {
    LEVEL_0,
    LEVEL_1,
    LEVEL_F,
    LEVEL_R
  } strap_level_type;

  typedef struct packed {
    strap_level_type equalizerStrapHigh;
    strap_level_type equalizerStrapLow;
    strap_level_type flatGainStrap;
    strap_level_type outputSwingStrap;
  } strap_levels_type;

  typedef struct packed {
    logic [1:0] signalDetectThreshold;
    logic [5:0] reservedBits;
    logic [3:0] equalizerCode;
    logic [1:0] flatGainCode;
    logic [1:0] outputSwingCode;
  } settings_type;

endpackage : conditioner_pkg
